// ### rtl/trigger_fpga_status_config_regs.sv
`timescale 1ns/1ps
`default_nettype none
`include "trigger_regs_map.svh"

module trigger_fpga_status_config_regs #(
  parameter logic [6:0] DEV_ADDR = 7'h2a  // arbitrary bus address
) (
  input  wire logic                          clk,
  input  wire logic                          rst,
  input  wire logic                          scl_in,
  input  wire logic                          sda_in,
  output logic                               sda_out,
  output logic                               sda_oe,
  input  wire logic                          sync_in,
  input  wire logic                          trig_one_in,
  input  wire logic                          trig_two_in,
  input  wire logic                          ref_clk_div_in,
  input  wire trigger_regs_pkg::link_status_t status,
  output trigger_regs_pkg::ctrl_t            ctrl
);

  // ==================================================
  // input synchronisers
  logic [2:0] scl_sr;
  logic [2:0] sda_sr;
  logic [2:0] ref_sr;
  logic [2:0] dist_s1;
  logic [2:0] dist_s2;
  logic [2:0] dist_s3;

  always_ff @(posedge clk) begin
    scl_sr  <= {scl_sr[1:0], scl_in};
    sda_sr  <= {sda_sr[1:0], sda_in};
    ref_sr  <= {ref_sr[1:0], ref_clk_div_in};
    dist_s1 <= {trig_two_in, trig_one_in, sync_in};
    dist_s2 <= dist_s1;
    dist_s3 <= dist_s2;
  end

  // bit 0 of each chain is the metastable stage, read only by bit 1
  wire scl_rise  = scl_sr[1] & ~scl_sr[2];
  wire scl_fall  = ~scl_sr[1] & scl_sr[2];
  wire scl_high  = scl_sr[1] & scl_sr[2];
  wire bus_start = scl_high & sda_sr[2] & ~sda_sr[1];
  wire bus_stop  = scl_high & ~sda_sr[2] & sda_sr[1];
  wire ref_rise  = ref_sr[1] & ~ref_sr[2];
  // pulses of 30 ns are only just over one 25 ns period
  wire [2:0] dist_rise = dist_s2 & ~dist_s3;

  // ==================================================
  // serial register port
  trigger_regs_pkg::i2c_state_t st_r;
  logic [2:0]  bitc_r;
  logic [1:0]  byte_idx_r;
  logic        rw_r;
  logic [7:0]  sh_r;
  logic [7:0]  ptr_r;
  logic [7:0]  wr_hi_r;
  logic [15:0] tx_sr_r;
  logic        lo_half_r;
  logic        drive_r;
  logic [15:0] rd_data;

  wire [7:0] rx_byte   = {sh_r[6:0], sda_sr[1]};
  wire       rx_last   = (st_r == trigger_regs_pkg::ST_RX) & scl_rise &
                         (bitc_r == 3'h7);
  wire       addr_miss = (byte_idx_r == 2'h0) & (rx_byte[7:1] != DEV_ADDR);
  wire       wr_stb    = rx_last & (byte_idx_r == 2'h3);
  wire [15:0] wr_data  = {wr_hi_r, rx_byte};
  // a word counts as read once its low byte has gone out
  wire       rd_done   = (st_r == trigger_regs_pkg::ST_MACK) & scl_rise &
                         lo_half_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      st_r       <= trigger_regs_pkg::ST_IDLE;
      bitc_r     <= 3'h0;
      byte_idx_r <= 2'h0;
      rw_r       <= 1'b0;
      sh_r       <= 8'h00;
      ptr_r      <= 8'h00;
      wr_hi_r    <= 8'h00;
      tx_sr_r    <= 16'h0000;
      lo_half_r  <= 1'b0;
      drive_r    <= 1'b0;
    end else if (bus_start) begin
      st_r       <= trigger_regs_pkg::ST_RX;
      bitc_r     <= 3'h0;
      byte_idx_r <= 2'h0;
      drive_r    <= 1'b0;
    end else if (bus_stop) begin
      st_r    <= trigger_regs_pkg::ST_IDLE;
      drive_r <= 1'b0;
    end else begin
      case (st_r)
        trigger_regs_pkg::ST_RX: begin
          if (scl_rise) begin
            sh_r   <= rx_byte;
            bitc_r <= bitc_r + 3'h1;
          end
          if (rx_last) begin
            st_r <= addr_miss ? trigger_regs_pkg::ST_IDLE
                              : trigger_regs_pkg::ST_RX_END;
            case (byte_idx_r)
              2'h0: begin
                rw_r       <= rx_byte[0];
                byte_idx_r <= 2'h1;
              end
              2'h1: begin
                ptr_r      <= rx_byte;
                byte_idx_r <= 2'h2;
              end
              2'h2: begin
                wr_hi_r    <= rx_byte;
                byte_idx_r <= 2'h3;
              end
              default: begin
                ptr_r      <= ptr_r + 8'h01;
                byte_idx_r <= 2'h2;
              end
            endcase
          end
        end
        trigger_regs_pkg::ST_RX_END: begin
          if (scl_fall) begin
            drive_r <= 1'b1;
            st_r    <= trigger_regs_pkg::ST_ACK;
          end
        end
        trigger_regs_pkg::ST_ACK: begin
          if (scl_fall) begin
            bitc_r <= 3'h0;
            if (rw_r) begin
              tx_sr_r   <= rd_data;
              drive_r   <= ~rd_data[15];
              lo_half_r <= 1'b0;
              st_r      <= trigger_regs_pkg::ST_TX;
            end else begin
              drive_r <= 1'b0;
              st_r    <= trigger_regs_pkg::ST_RX;
            end
          end
        end
        trigger_regs_pkg::ST_TX: begin
          if (scl_rise) begin
            bitc_r <= bitc_r + 3'h1;
            if (bitc_r == 3'h7) begin
              st_r <= trigger_regs_pkg::ST_TX_END;
            end
          end
          if (scl_fall) begin
            tx_sr_r <= {tx_sr_r[14:0], 1'b0};
            drive_r <= ~tx_sr_r[14];
          end
        end
        trigger_regs_pkg::ST_TX_END: begin
          if (scl_fall) begin
            tx_sr_r <= {tx_sr_r[14:0], 1'b0};
            drive_r <= 1'b0;
            st_r    <= trigger_regs_pkg::ST_MACK;
          end
        end
        trigger_regs_pkg::ST_MACK: begin
          if (scl_rise) begin
            if (lo_half_r) begin
              ptr_r <= ptr_r + 8'h01;
            end
            st_r <= sda_sr[1] ? trigger_regs_pkg::ST_IDLE
                              : trigger_regs_pkg::ST_NEXT;
          end
        end
        trigger_regs_pkg::ST_NEXT: begin
          if (scl_fall) begin
            bitc_r <= 3'h0;
            st_r   <= trigger_regs_pkg::ST_TX;
            if (lo_half_r) begin
              tx_sr_r   <= rd_data;
              drive_r   <= ~rd_data[15];
              lo_half_r <= 1'b0;
            end else begin
              drive_r   <= ~tx_sr_r[15];
              lo_half_r <= 1'b1;
            end
          end
        end
        default: begin
          st_r <= trigger_regs_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // open drain: only ever pull low
  assign sda_out = 1'b0;
  assign sda_oe  = drive_r;

  // ==================================================
  // configuration registers
  logic [5:0]  payload_en_r;
  logic [3:0]  xcvr_r;
  logic [31:0] thr_r;
  logic [2:0]  edge_ctl_r;
  logic [15:0] crate_r;
  logic [15:0] mode_r;
  logic [15:0] gen4_r;
  logic [15:0] gen5_r;
  logic [15:0] gen6_r;
  logic        latch_pulse_r;
  logic        hist_adv_r;

  function automatic logic wr_hit(input logic       stb,
                                  input logic [7:0] addr,
                                  input logic [7:0] off);
    wr_hit = stb & (addr == off);
  endfunction

  wire wr_mode   = wr_hit(wr_stb, ptr_r, `OFF_COUNTER_MODE);
  wire wr_edge   = wr_hit(wr_stb, ptr_r, `OFF_EDGE_CLEAR);
  wire latch_now = wr_mode & wr_data[`MODE_LATCH] &
                   ~mode_r[`MODE_LATCH];

  always_ff @(posedge clk) begin
    if (rst) begin
      payload_en_r <= 6'h00;
      xcvr_r       <= 4'h0;
      thr_r        <= 32'h0000_0000;
      edge_ctl_r   <= 3'h0;
      crate_r      <= `CFG_RESET;
      mode_r       <= `CFG_RESET;
      gen4_r       <= `CFG_RESET;
      gen5_r       <= `CFG_RESET;
      gen6_r       <= `CFG_RESET;
    end else begin
      if (wr_hit(wr_stb, ptr_r, `OFF_PAYLOAD_ENABLE)) begin
        payload_en_r <= wr_data[5:0];
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_XCVR_CONTROL)) begin
        xcvr_r <= wr_data[3:0];
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_THRESHOLD_LOW)) begin
        thr_r[15:0] <= wr_data;
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_THRESHOLD_HIGH)) begin
        thr_r[31:16] <= wr_data;
      end
      if (wr_edge) begin
        edge_ctl_r <= wr_data[2:0];
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_CRATE_ID)) begin
        crate_r <= wr_data;
      end
      if (wr_mode) begin
        mode_r <= wr_data;
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_GENERAL_FOUR)) begin
        gen4_r <= wr_data;
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_GENERAL_FIVE)) begin
        gen5_r <= wr_data;
      end
      if (wr_hit(wr_stb, ptr_r, `OFF_GENERAL_SIX)) begin
        gen6_r <= wr_data;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      latch_pulse_r <= 1'b0;
      hist_adv_r    <= 1'b0;
    end else begin
      latch_pulse_r <= latch_now;
      hist_adv_r    <= rd_done & (ptr_r == `OFF_HISTORY_HIGH);
    end
  end

  // ==================================================
  // edge counters
  function automatic logic [15:0] count_next(input logic [15:0] cnt,
                                             input logic        clr,
                                             input logic        hit);
    // an edge in the clearing cycle is kept: it counts as the first
    count_next = clr ? {15'h0000, hit} : cnt + {15'h0000, hit};
  endfunction

  logic [2:0][15:0] cnt_r;
  logic [2:0][15:0] snap_r;
  logic [2:0]       cnt_clr;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_cnt
      assign cnt_clr[gi] = (wr_edge & wr_data[gi]) |
                           (mode_r[`MODE_CLEAR_ON_READ] & rd_done &
                            (ptr_r == `OFF_SYNC_COUNT + 8'(gi)));
      always_ff @(posedge clk) begin
        if (rst) begin
          cnt_r[gi]  <= 16'h0000;
          snap_r[gi] <= 16'h0000;
        end else begin
          cnt_r[gi] <= count_next(cnt_r[gi], cnt_clr[gi],
                                  dist_rise[gi]);
          if (latch_now) begin
            snap_r[gi] <= cnt_r[gi];
          end
        end
      end
    end
  endgenerate

  // counter mode reads the latched copies so all counts agree in time
  wire [2:0][15:0] cnt_view = mode_r[`MODE_SPECTROMETER] ? snap_r : cnt_r;

  // ==================================================
  // reference clock frequency
  // the divided clock edges in a 32 us gate equal the rate in MHz
  localparam logic [10:0] GATE_LAST = 11'(`GATE_CYCLES - 1);
  logic [10:0] gate_r;
  logic [7:0]  ref_cnt_r;
  logic [7:0]  freq_r;

  wire [7:0] ref_cnt_inc = (ref_cnt_r == 8'hff) ? ref_cnt_r
                                                : ref_cnt_r + 8'(ref_rise);

  always_ff @(posedge clk) begin
    if (rst) begin
      gate_r    <= 11'h000;
      ref_cnt_r <= 8'h00;
      freq_r    <= 8'h00;
    end else if (gate_r == GATE_LAST) begin
      gate_r    <= 11'h000;
      ref_cnt_r <= 8'h00;
      freq_r    <= ref_cnt_inc;
    end else begin
      gate_r    <= gate_r + 11'h001;
      ref_cnt_r <= ref_cnt_inc;
    end
  end

  // ==================================================
  // read selection
  wire [5:0] cu = status.chan_up;
  wire [15:0] lanes_word = {cu[1], cu[4], cu[0], cu[2],
                            status.lane_up[5], status.lane_up[3],
                            status.lane_up[1], status.lane_up[4],
                            status.lane_up[0], status.lane_up[2]};
  wire [15:0] fiber_word = {6'h00,
                            status.alignment_complete,
                            status.sum_error,
                            status.fiber_ready,
                            status.fiber_remote_up,
                            status.fiber_byte_align,
                            status.fiber_chan_align,
                            status.history_ready,
                            cu[5], &cu, cu[3]};

  always_comb begin
    case (ptr_r)
      `OFF_LINK_STATUS_LANES: rd_data = lanes_word;
      `OFF_LINK_FIBER_STATUS: rd_data = fiber_word;
      `OFF_PAYLOAD_ENABLE:    rd_data = {10'h000, payload_en_r};
      `OFF_XCVR_CONTROL:      rd_data = {12'h000, xcvr_r};
      `OFF_DIE_TEMPERATURE:   rd_data = status.die_temp;
      `OFF_CORE_VOLTAGE:      rd_data = status.core_volt;
      `OFF_THRESHOLD_LOW:     rd_data = thr_r[15:0];
      `OFF_THRESHOLD_HIGH:    rd_data = thr_r[31:16];
      `OFF_HISTORY_LOW:       rd_data = status.history_data[15:0];
      `OFF_HISTORY_HIGH:      rd_data = status.history_data[31:16];
      `OFF_EDGE_CLEAR:        rd_data = {13'h0000, edge_ctl_r};
      `OFF_REF_FREQUENCY:     rd_data = {8'h00, freq_r};
      `OFF_SYNC_COUNT:        rd_data = cnt_view[0];
      `OFF_TRIG_ONE_COUNT:    rd_data = cnt_view[1];
      `OFF_TRIG_TWO_COUNT:    rd_data = cnt_view[2];
      `OFF_FW_REVISION:       rd_data = {1'b0, status.fw_version};
      `OFF_CRATE_ID:          rd_data = crate_r;
      `OFF_COUNTER_MODE:      rd_data = mode_r;
      `OFF_GENERAL_FOUR:      rd_data = gen4_r;
      `OFF_GENERAL_FIVE:      rd_data = gen5_r;
      `OFF_GENERAL_SIX:       rd_data = gen6_r;
      default:                rd_data = 16'h0000;
    endcase
  end

  // ==================================================
  // control outputs
  assign ctrl.payload_enable   = payload_en_r;
  assign ctrl.align_enable     = xcvr_r[`XCVR_ALIGN_ENABLE];
  assign ctrl.fiber_reset      = xcvr_r[`XCVR_FIBER_RESET];
  assign ctrl.init_all         = xcvr_r[`XCVR_INIT_ALL];
  assign ctrl.history_arm      = xcvr_r[`XCVR_HISTORY_ARM];
  assign ctrl.threshold        = thr_r;
  assign ctrl.crate_id         = crate_r;
  assign ctrl.counter_mode     = mode_r[`MODE_SPECTROMETER];
  assign ctrl.clear_after_read = mode_r[`MODE_CLEAR_ON_READ];
  assign ctrl.latch_pulse      = latch_pulse_r;
  assign ctrl.coinc_width      = mode_r[3:0];
  assign ctrl.general_four     = gen4_r;
  assign ctrl.general_five     = gen5_r;
  assign ctrl.general_six      = gen6_r;
  assign ctrl.history_advance  = hist_adv_r;

endmodule

`default_nettype wire

// ### rtl/trigger_regs_map.svh
`ifndef TRIGGER_REGS_MAP_SVH
`define TRIGGER_REGS_MAP_SVH

// ==================================================
// register offsets
`define OFF_LINK_STATUS_LANES  8'h00
`define OFF_LINK_FIBER_STATUS  8'h01
`define OFF_PAYLOAD_ENABLE     8'h02
`define OFF_XCVR_CONTROL       8'h03
`define OFF_DIE_TEMPERATURE    8'h04
`define OFF_CORE_VOLTAGE       8'h05
`define OFF_THRESHOLD_LOW      8'h08
`define OFF_THRESHOLD_HIGH     8'h09
`define OFF_HISTORY_LOW        8'h0a
`define OFF_HISTORY_HIGH       8'h0b
`define OFF_EDGE_CLEAR         8'h0c
`define OFF_REF_FREQUENCY      8'h0d
`define OFF_SYNC_COUNT         8'h0e
`define OFF_TRIG_ONE_COUNT     8'h0f
`define OFF_TRIG_TWO_COUNT     8'h10
`define OFF_FW_REVISION        8'h11
`define OFF_CRATE_ID           8'h12
`define OFF_COUNTER_MODE       8'h13
`define OFF_GENERAL_FOUR       8'h14
`define OFF_GENERAL_FIVE       8'h15
`define OFF_GENERAL_SIX        8'h16

// ==================================================
// field positions
`define XCVR_HISTORY_ARM       0
`define XCVR_INIT_ALL          1
`define XCVR_FIBER_RESET       2
`define XCVR_ALIGN_ENABLE      3
`define MODE_SPECTROMETER      15
`define MODE_CLEAR_ON_READ     7
`define MODE_LATCH             6

// ==================================================
// reset values
`define CFG_RESET              16'h0000

// ==================================================
// timing
`define CLK_MHZ                40
`define PULSE_MIN_NS           30
`define REF_DIVIDE             32
`define GATE_US                32
`define GATE_CYCLES            (`GATE_US * `CLK_MHZ)

`endif

// ### rtl/trigger_regs_pkg.sv
`default_nettype none
package trigger_regs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_RX     = 3'b001,
    ST_RX_END = 3'b010,
    ST_ACK    = 3'b011,
    ST_TX     = 3'b100,
    ST_TX_END = 3'b101,
    ST_MACK   = 3'b110,
    ST_NEXT   = 3'b111
  } i2c_state_t;

  typedef struct packed {
    logic [5:0][1:0] lane_up;
    logic [5:0]      chan_up;
    logic            fiber_ready;
    logic            fiber_remote_up;
    logic            fiber_byte_align;
    logic            fiber_chan_align;
    logic            sum_error;
    logic            history_ready;
    logic            alignment_complete;
    logic [15:0]     die_temp;
    logic [15:0]     core_volt;
    logic [14:0]     fw_version;
    logic [31:0]     history_data;
  } link_status_t;

  typedef struct packed {
    logic [5:0]  payload_enable;
    logic        align_enable;
    logic        fiber_reset;
    logic        init_all;
    logic        history_arm;
    logic [31:0] threshold;
    logic [15:0] crate_id;
    logic        counter_mode;
    logic        clear_after_read;
    logic        latch_pulse;
    logic [3:0]  coinc_width;
    logic [15:0] general_four;
    logic [15:0] general_five;
    logic [15:0] general_six;
    logic        history_advance;
  } ctrl_t;

endpackage
`default_nettype wire

// ### verif/trigger_regs_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// port checks of the register block
module trigger_regs_sva (
  input wire logic                    clk,
  input wire logic                    rst,
  input wire logic                    scl_in,
  input wire logic                    sda_oe,
  input wire trigger_regs_pkg::ctrl_t ctrl
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // level part of ctrl only; the two pulses have checks of their own
  trigger_regs_pkg::ctrl_t cfg_lvl;
  always_comb begin
    cfg_lvl = ctrl;
    cfg_lvl.latch_pulse = 1'b0;
    cfg_lvl.history_advance = 1'b0;
  end
  reset_clear_a: assert property ($fell(rst) |->
    ctrl == '0 && !sda_oe) else $error("ctrl or sda_oe not cleared by reset");
  // writes commit on an scl rise, so a quiet low clock freezes the levels
  cfg_hold_a: assert property ((!$past(rst) && !scl_in) [*5] |=>
    $stable(cfg_lvl)) else $error("config level moved while scl low");
  latch_one_a: assert property (ctrl.latch_pulse |=>
    !ctrl.latch_pulse [*8]) else $error("latch pulse too long");
  latch_bus_a: assert property (ctrl.latch_pulse |->
    $past(scl_in, 2) && !sda_oe) else $error("latch pulse off a write");
  adv_one_a: assert property (ctrl.history_advance |=>
    !ctrl.history_advance [*8]) else $error("history advance too long");
  adv_ack_a: assert property (ctrl.history_advance |->
    !sda_oe && $past(scl_in, 2)) else $error("advance off the host ack");
  data_hold_a: assert property (scl_in [*5] |-> $stable(sda_oe))
    else $error("sda moved while scl high");
  oe_edge_a: assert property ($changed(sda_oe) |->
    !$past(scl_in, 2)) else $error("sda changed too soon after scl");
endmodule
`default_nettype wire

// ### verif/i2c_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// serial bus host: drives scl, pulls sda low while sda_oe is high
module i2c_host_model (
  input  wire logic clk,
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_oe
);
  int nacks = 0;
  initial begin
    scl = 1'b1;
    sda_oe = 1'b0;
  end
  // ten clocks a phase, above the eight the device needs
  task automatic half();
    repeat (10) @(posedge clk);
    #1;
  endtask
  // sda moves a few clocks after scl falls, never beside an scl edge
  task automatic lead();
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic xbit(input logic b, output logic r);
    lead();
    sda_oe = ~b;
    half();
    scl = 1'b1;
    half();
    r = sda_line;
    scl = 1'b0;
  endtask
  task automatic xbyte(input logic [7:0] d, input logic ak,
                       output logic [7:0] r, output logic a);
    for (int i = 7; i >= 0; i--) xbit(d[i], r[i]);
    xbit(ak, a);
  endtask
  task automatic send(input logic [7:0] d);
    logic [7:0] r;
    logic       a;
    xbyte(d, 1'b1, r, a);
    if (a) nacks++;
  endtask
  // also a repeated start: sda released before scl rises
  task automatic start();
    lead();
    sda_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b1;
    half();
    scl = 1'b0;
  endtask
  task automatic stop();
    lead();
    sda_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    sda_oe = 1'b0;
    half();
  endtask
  task automatic wr(input logic [6:0] dev, input logic [7:0] off,
                    input logic [15:0] d);
    start();
    send({dev, 1'b0});
    send(off);
    send(d[15:8]);
    send(d[7:0]);
    stop();
  endtask
  // callers read the history low word before the high word
  task automatic rd(input logic [6:0] dev, input logic [7:0] off,
                    output logic [15:0] d);
    logic a;
    start();
    send({dev, 1'b0});
    send(off);
    start();
    send({dev, 1'b1});
    xbyte(8'hff, 1'b0, d[15:8], a);
    xbyte(8'hff, 1'b1, d[7:0], a);
    stop();
  endtask
endmodule
`default_nettype wire

// ### verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
// ====================
// bench top
module tb_top;
  localparam logic [6:0] ADDR = 7'h2a;
  logic                           clk;
  logic                           rst;
  logic                           scl;
  logic                           host_oe;
  logic                           dut_oe;
  logic                           dut_out;
  logic                           ref_div;
  logic [2:0]                     pin;
  trigger_regs_pkg::link_status_t st;
  trigger_regs_pkg::ctrl_t        ctrl;
  int                             failures;
  int                             checks_done;
  int                             latches;
  int                             advances;
  logic [15:0]                    v;
  // open drain with pull-up
  wire logic sda = (dut_oe ? dut_out : 1'b1) & ~host_oe;
  wire logic [3:0] xc = {ctrl.align_enable, ctrl.fiber_reset,
                         ctrl.init_all, ctrl.history_arm};
  wire logic [5:0] md = {ctrl.counter_mode, ctrl.clear_after_read,
                         ctrl.coinc_width};
  trigger_fpga_status_config_regs #(.DEV_ADDR(ADDR)) i_dut (
    .clk(clk), .rst(rst), .scl_in(scl), .sda_in(sda), .sda_out(dut_out),
    .sda_oe(dut_oe), .sync_in(pin[0]), .trig_one_in(pin[1]),
    .trig_two_in(pin[2]), .ref_clk_div_in(ref_div), .status(st),
    .ctrl(ctrl));
  i2c_host_model i_host (.clk(clk), .sda_line(sda), .scl(scl),
    .sda_oe(host_oe));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // divided reference: 250 MHz over 32 gives 128 ns
  initial begin
    ref_div = 1'b0;
    forever #64 ref_div = ~ref_div;
  end
  always @(posedge clk) begin
    latches += int'(ctrl.latch_pulse === 1'b1);
    advances += int'(ctrl.history_advance === 1'b1);
  end
  task automatic chk16(string n, logic [15:0] e, logic [15:0] g);
    checks_done++;
    if (g !== e) begin
      failures++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask
  task automatic rchk(string n, logic [7:0] a, logic [15:0] e);
    i_host.rd(ADDR, a, v);
    chk16(n, e, v);
  endtask
  // three clocks high, past the 30 ns minimum and the synchroniser
  task automatic pulse(int k, int n);
    repeat (n) begin
      pin[k] = 1'b1;
      repeat (3) @(posedge clk);
      #1 pin[k] = 1'b0;
      repeat (3) @(posedge clk);
      #1;
    end
  endtask
  task automatic t_cfg();
    chk16("ctrl idle", 16'h0001, 16'(ctrl == '0));
    rchk("enables reset", 8'h02, 16'h0000);
    i_host.wr(ADDR, 8'h02, 16'h002b);
    chk16("enables", 16'h002b, {10'h0, ctrl.payload_enable});
    i_host.wr(ADDR, 8'h03, 16'h000a);
    chk16("xcvr bits", 16'h000a, {12'h0, xc});
    i_host.wr(ADDR, 8'h03, 16'h0005);
    chk16("xcvr bits", 16'h0005, {12'h0, xc});
    i_host.wr(ADDR, 8'h08, 16'hbeef);
    i_host.wr(ADDR, 8'h09, 16'h1234);
    chk16("thr low", 16'hbeef, ctrl.threshold[15:0]);
    chk16("thr high", 16'h1234, ctrl.threshold[31:16]);
    rchk("thr read", 8'h09, 16'h1234);
    for (int a = 18; a <= 22; a++) begin
      if (a != 19) begin
        i_host.wr(ADDR, 8'(a), 16'h5a00 | 16'(a));
        rchk("general", 8'(a), 16'h5a00 | 16'(a));
      end
    end
    chk16("crate id", 16'h5a12, ctrl.crate_id);
    chk16("general 4", 16'h5a14, ctrl.general_four);
    chk16("general 5", 16'h5a15, ctrl.general_five);
    chk16("general 6", 16'h5a16, ctrl.general_six);
    $display("config test done");
  endtask
  task automatic t_status(logic [5:0] cu, logic [11:0] lu, logic [6:0] fl);
    logic [15:0] e0;
    logic [9:0]  e1;
    st.chan_up = cu;
    st.lane_up = lu;
    {st.alignment_complete, st.sum_error, st.fiber_ready, st.fiber_remote_up,
     st.fiber_byte_align, st.fiber_chan_align, st.history_ready} = fl;
    e0 = {cu[1], cu[4], cu[0], cu[2], lu[11:10], lu[7:6], lu[3:2],
          lu[9:8], lu[1:0], lu[5:4]};
    e1 = {fl, cu[5], &cu, cu[3]};
    rchk("status 0", 8'h00, e0);
    i_host.rd(ADDR, 8'h01, v);
    chk16("status 1", {6'h0, e1}, v);
    $display("status test done");
  endtask
  task automatic t_ro();
    int n0;
    int a0;
    st.history_data = 32'hcafe1234;
    st.die_temp = 16'h0123;
    st.core_volt = 16'h0456;
    st.fw_version = 15'h7abc;
    a0 = advances;
    rchk("hist low", 8'h0a, 16'h1234);
    chk16("no advance", 16'(a0), 16'(advances));
    rchk("hist high", 8'h0b, 16'hcafe);
    chk16("one advance", 16'(a0 + 1), 16'(advances));
    i_host.wr(ADDR, 8'h0a, 16'h0f0f);
    rchk("hist ro", 8'h0a, 16'h1234);
    i_host.wr(ADDR, 8'h06, 16'h0f0f);
    rchk("spare", 8'h06, 16'h0000);
    rchk("unmapped", 8'h17, 16'h0000);
    rchk("temp", 8'h04, 16'h0123);
    rchk("volt", 8'h05, 16'h0456);
    rchk("revision", 8'h11, 16'h7abc);
    n0 = i_host.nacks;
    i_host.wr(ADDR ^ 7'h01, 8'h02, 16'h0000);
    chk16("foreign addr", 16'h0001, 16'(i_host.nacks > n0));
    chk16("enables kept", 16'h002b, {10'h0, ctrl.payload_enable});
    $display("read-only test done");
  endtask
  task automatic t_count();
    pulse(0, 3);
    pulse(1, 5);
    pulse(2, 2);
    rchk("sync cnt", 8'h0e, 16'h0003);
    rchk("first_trigger_input cnt", 8'h0f, 16'h0005);
    rchk("second_trigger_input cnt", 8'h10, 16'h0002);
    i_host.wr(ADDR, 8'h0c, 16'h0005);
    rchk("sync clr", 8'h0e, 16'h0000);
    rchk("first_trigger_input kept", 8'h0f, 16'h0005);
    rchk("second_trigger_input clr", 8'h10, 16'h0000);
    i_host.wr(ADDR, 8'h0c, 16'h0002);
    rchk("first_trigger_input clr", 8'h0f, 16'h0000);
    $display("counter test done");
  endtask
  task automatic t_mode();
    int l0;
    i_host.wr(ADDR, 8'h13, 16'h0089);
    chk16("mode", 16'h0019, {10'h0, md});
    pulse(1, 2);
    rchk("before rd", 8'h0f, 16'h0002);
    rchk("after rd", 8'h0f, 16'h0000);
    i_host.wr(ADDR, 8'h13, 16'h0009);
    pulse(0, 4);
    l0 = latches;
    i_host.wr(ADDR, 8'h13, 16'h8049);
    chk16("latch", 16'(l0 + 1), 16'(latches));
    chk16("mode", 16'h0029, {10'h0, md});
    pulse(0, 1);
    rchk("snapshot", 8'h0e, 16'h0004);
    i_host.wr(ADDR, 8'h13, 16'h0009);
    rchk("live", 8'h0e, 16'h0005);
    i_host.rd(ADDR, 8'h0d, v);
    chk16("freq", 16'h0001, 16'(v[7:0] >= 8'hf8 && v[7:0] <= 8'hfc));
    chk16("freq high", 16'h0000, {8'h00, v[15:8]});
    $display("mode test done");
  endtask
  task automatic end_sim();
    $display("checks %0d, failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    rst = 1'b1;
    pin = 3'b000;
    st = '0;
    repeat (5) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    #1;
    t_cfg();
    t_status(6'h3f, 12'h5a3, 7'h55);
    t_status(6'h2e, 12'ha5c, 7'h2a);
    t_ro();
    t_count();
    t_mode();
    end_sim();
  end
  // about 50k cycles expected
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    $display("watchdog expired");
    end_sim();
  end
endmodule
bind trigger_fpga_status_config_regs trigger_regs_sva i_sva (
  .clk(clk), .rst(rst), .scl_in(scl_in), .sda_oe(sda_oe), .ctrl(ctrl));
`default_nettype wire
